// File: verilog/omf_top.sv
// output mute, dither, filter select, fault latch and tdm cascade output
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module omf_top import omf_pkg::*; (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic [11:0] paddr, // apb byte address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write when high
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error for unmapped address
  input wire logic power_down_n, // power-down pin, low powers down
  input wire logic control_mode_select, // high parallel, low serial control
  input wire logic soft_mute_request, // soft mute pin
  input wire logic short_delay_select, // filter pin, short delay
  input wire logic slow_rolloff_select, // filter pin, slow roll-off
  input wire logic [1:0] deemphasis_select, // de-emphasis pins
  input wire logic [1:0] output_word_length, // word length pins
  input wire logic bypass_mode, // converter bypassed when high
  input wire logic tdm_mode, // tdm output format when high
  input wire logic over_current, // regulator over-current detect
  input wire logic over_voltage, // regulator over-voltage detect
  input wire logic output_frame_clock, // output frame clock pin
  input wire logic output_bit_clock, // output bit clock pin
  input wire logic cascade_tdm_in, // upstream tdm serial data
  input wire logic [31:0] sample_left, // converted left sample
  input wire logic [31:0] sample_right, // converted right sample
  output logic serial_data_out, // serial audio output
  output logic fault_status_out, // high on fault or power-down
  output logic regulator_enable, // regulator powered when high
  output logic [1:0] filter_mode, // selected interpolation filter
  output logic [1:0] deemph_mode // selected de-emphasis
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] pinSync;
  logic lrckDly;
  logic bclkDly;
  logic frameRise;
  logic frameFall;
  logic bclkRise;
  logic bclkFall;
  logic pwrOn;
  logic parallelMode;
  logic tdmOn;
  logic bypassOn;
  logic faultIn;

  // gather every outside pin into one bank
  assign pinRaw = {cascade_tdm_in, output_bit_clock, output_frame_clock, over_voltage,
                   over_current, tdm_mode, bypass_mode, output_word_length,
                   deemphasis_select, slow_rolloff_select, short_delay_select,
                   soft_mute_request, control_mode_select, power_down_n};

  omf_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pinRaw),
    .dout(pinSync)
  );

  // named views of the synchronised pins
  assign pwrOn = pinSync[SY_PWRDN];
  assign parallelMode = pinSync[SY_MODE];
  assign tdmOn = pinSync[SY_TDM];
  assign bypassOn = pinSync[SY_BYPASS];
  assign faultIn = pinSync[SY_OVC] | pinSync[SY_OVV];

  // delayed copies of the sampled clocks for edge finding
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lrckDly <= 1'b0;
      bclkDly <= 1'b0;
    end else begin
      lrckDly <= pinSync[SY_LRCK];
      bclkDly <= pinSync[SY_BCLK];
    end
  end

  assign frameRise = pinSync[SY_LRCK] & ~lrckDly;
  assign frameFall = ~pinSync[SY_LRCK] & lrckDly;
  assign bclkRise = pinSync[SY_BCLK] & ~bclkDly;
  assign bclkFall = ~pinSync[SY_BCLK] & bclkDly;

  ////////////////////////////////////////////////////////////////////////////
  // apb register slave, one wait state per transfer

  logic [CTL_W-1:0] ctrl;
  logic [31:0] status;
  logic mapped;
  logic accessDone;
  logic faultLatch;
  logic semiActive;
  logic [LEVEL_W-1:0] level;
  logic rampBusy;

  assign mapped = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS);
  assign accessDone = psel & penable & pready;

  // status word built from live block state
  always_comb begin
    status = 32'h0000_0000;
    status[STS_FAULT] = faultLatch;
    status[STS_AT_ZERO] = (level == LEVEL_MUTE);
    status[STS_BUSY] = rampBusy;
    status[STS_SEMI] = semiActive;
    status[STS_LEVEL_LO +: LEVEL_W] = level;
  end

  // ready, read data and error are all registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite && paddr == ADDR_CONTROL) begin
        prdata <= {21'h000000, ctrl};
      end else if (psel && penable && !pready && !pwrite && paddr == ADDR_STATUS) begin
        prdata <= status;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // control register write at the completing edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= CTL_RESET;
    end else if (accessDone && pwrite && paddr == ADDR_CONTROL) begin
      ctrl <= pwdata[CTL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulator fault latch and power-down

  logic runOk;
  logic softResetBit;
  logic softHold;
  logic softResetDly;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      faultLatch <= 1'b0;
    end else if (faultIn) begin
      faultLatch <= 1'b1;
    end else if (!pwrOn) begin
      faultLatch <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_status_out <= 1'b1;
      regulator_enable <= 1'b0;
    end else begin
      fault_status_out <= ~pwrOn | faultLatch | faultIn;
      regulator_enable <= pwrOn & ~faultLatch & ~faultIn;
    end
  end

  assign runOk = pwrOn & ~faultLatch;
  assign softResetBit = ctrl[CTL_SOFT_RESET_N];
  assign softHold = ~parallelMode & ~softResetBit;

  ////////////////////////////////////////////////////////////////////////////
  // soft mute control and semi-automatic release

  omf_ramp_if rampBus ();
  logic muteReq;
  logic muteBit;
  logic semiArm;
  logic [12:0] semiCount;

  assign muteBit = ctrl[CTL_SOFT_MUTE];
  assign semiArm = ~parallelMode & ctrl[CTL_SEMI_AUTO] & muteBit;

  assign muteReq = parallelMode ? pinSync[SY_MUTE] : muteBit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      softResetDly <= 1'b1;
      semiActive <= 1'b0;
      semiCount <= 13'h0000;
    end else begin
      softResetDly <= softResetBit;
      if (!runOk || softHold) begin
        semiActive <= 1'b0;
        semiCount <= 13'h0000;
      end else if (softResetBit && !softResetDly && semiArm) begin
        semiActive <= 1'b1;
        semiCount <= 13'h0000;
      end else if (semiActive && frameRise) begin
        if (semiCount == SEMI_FRAMES - 13'h0001) begin
          semiActive <= 1'b0;
        end
        semiCount <= semiCount + 13'h0001;
      end
    end
  end

  assign rampBus.request = muteReq | semiActive;
  assign rampBus.frameTick = frameRise;
  assign rampBus.periodSel = parallelMode ? PERIOD_DEFAULT : ctrl[CTL_PERIOD_LO +: 3];
  assign rampBus.clear = ~runOk | softHold;
  assign rampBus.clearLevel = (semiArm & softHold) ? LEVEL_MUTE : LEVEL_FULL;
  assign level = rampBus.level;
  assign rampBusy = rampBus.busy;

  omf_ramp u_ramp (
    .clk_sys(clk_sys),
    .rst(rst),
    .rp(rampBus.ramp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // filter and de-emphasis selection

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      filter_mode <= 2'h0;
      deemph_mode <= 2'h1;
    end else if (parallelMode) begin
      filter_mode <= {pinSync[SY_SHORT], pinSync[SY_SLOW]};
      deemph_mode <= pinSync[SY_DEEMPH_LO +: 2];
    end else begin
      filter_mode <= {ctrl[CTL_SHORT_DELAY], ctrl[CTL_SLOW_ROLLOFF]};
      deemph_mode <= ctrl[CTL_DEEMPH_LO +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample shaping: attenuation, dither, word length

  logic [15:0] lfsr;
  logic [1:0] wlCode;
  logic [31:0] wordL;
  logic [31:0] wordR;

  // scale a sample by the attenuation level, 0 dB at full scale
  function automatic logic [31:0] omf_scale(input logic [31:0] w, input logic [LEVEL_W-1:0] lv);
    logic signed [43:0] prod;
    prod = $signed(w) * $signed({1'b0, lv});
    return prod[41:10];
  endfunction : omf_scale

  // add dither below the kept lsb, saturate, then clear the dropped bits
  function automatic logic [31:0] omf_shape(input logic [31:0] w, input logic [1:0] wl,
                                            input logic dith, input logic rnd);
    logic [4:0] pos;
    logic [32:0] sum;
    logic [31:0] res;
    case (wl)
      2'h0: pos = POS_32;
      2'h1: pos = POS_24;
      2'h2: pos = POS_20;
      default: pos = POS_16;
    endcase
    sum = {w[31], w};
    if (dith && rnd && pos != POS_32) begin
      sum = sum + (33'h1 << (pos - 5'h01));
    end
    if (sum[32] != sum[31]) begin
      res = sum[32] ? 32'h8000_0000 : 32'h7fff_ffff;
    end else begin
      res = sum[31:0];
    end
    return res & (32'hffff_ffff << pos);
  endfunction : omf_shape

  // tdm output is always 32 bits wide
  assign wlCode = tdmOn ? 2'h0 : pinSync[SY_WL_LO +: 2];

  always_comb begin
    wordL = omf_shape(bypassOn ? sample_left : omf_scale(sample_left, level), wlCode,
                      ctrl[CTL_DITHER], lfsr[0]);
    wordR = omf_shape(bypassOn ? sample_right : omf_scale(sample_right, level), wlCode,
                      ctrl[CTL_DITHER], lfsr[1]);
  end

  // dither source advances once per frame
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lfsr <= LFSR_SEED;
    end else if (frameRise) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output and tdm cascade

  logic [63:0] shiftReg;
  logic [31:0] rightHold;
  logic [7:0] bitCount;
  logic [63:0] cascDelay;
  logic outRun;

  assign outRun = runOk & ~softHold;

  // upstream channels delayed by two slots
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cascDelay <= 64'h0;
    end else if (!outRun) begin
      cascDelay <= 64'h0;
    end else if (bclkRise) begin
      cascDelay <= {cascDelay[62:0], pinSync[SY_CASC]};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      serial_data_out <= 1'b0;
      shiftReg <= 64'h0;
      rightHold <= 32'h0;
      bitCount <= 8'h00;
    end else if (!outRun) begin
      serial_data_out <= 1'b0;
      shiftReg <= 64'h0;
      rightHold <= 32'h0;
      bitCount <= 8'h00;
    end else if (frameRise) begin
      serial_data_out <= wordL[31];
      shiftReg <= tdmOn ? {wordL[30:0], wordR, 1'b0} : {wordL[30:0], 33'h0};
      rightHold <= wordR;
      bitCount <= 8'h01;
    end else if (frameFall && !tdmOn) begin
      serial_data_out <= rightHold[31];
      shiftReg <= {rightHold[30:0], 33'h0};
      bitCount <= 8'h01;
    end else if (bclkFall) begin
      if (tdmOn && bitCount >= OWN_BITS) begin
        serial_data_out <= cascDelay[63];
      end else begin
        serial_data_out <= shiftReg[63];
      end
      shiftReg <= {shiftReg[62:0], 1'b0};
      if (bitCount != 8'hff) begin
        bitCount <= bitCount + 8'h01;
      end
    end
  end

endmodule : omf_top

// File: verilog/omf_pkg.sv
// constants shared by the output mute and filter control block
package omf_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  // control register field positions
  localparam int CTL_SOFT_RESET_N = 0;
  localparam int CTL_SOFT_MUTE = 1;
  localparam int CTL_SEMI_AUTO = 2;
  localparam int CTL_DITHER = 3;
  localparam int CTL_PERIOD_LO = 4;
  localparam int CTL_SHORT_DELAY = 7;
  localparam int CTL_SLOW_ROLLOFF = 8;
  localparam int CTL_DEEMPH_LO = 9;
  localparam int CTL_W = 11;
  // control reset value: soft reset released, de-emphasis off, sharp filter
  localparam logic [CTL_W-1:0] CTL_RESET = 11'h201;
  // status register field positions
  localparam int STS_FAULT = 0;
  localparam int STS_AT_ZERO = 1;
  localparam int STS_BUSY = 2;
  localparam int STS_SEMI = 3;
  localparam int STS_LEVEL_LO = 16;
  // attenuation level: full scale is 0 dB, zero is full mute
  localparam int LEVEL_W = 11;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 11'h400;
  localparam logic [LEVEL_W-1:0] LEVEL_MUTE = 11'h000;
  // ramp period codes: 1024 frames times two to the code, 6 and 7 reserved
  localparam logic [2:0] PERIOD_DEFAULT = 3'h0;
  localparam logic [2:0] PERIOD_LAST = 3'h5;
  localparam int PRESCALE_W = 5;
  // frames of forced mute after a semi-automatic reset release
  localparam logic [12:0] SEMI_FRAMES = 13'h113a;
  // lowest kept bit for each output word length code
  localparam logic [4:0] POS_32 = 5'h00;
  localparam logic [4:0] POS_24 = 5'h08;
  localparam logic [4:0] POS_20 = 5'h0c;
  localparam logic [4:0] POS_16 = 5'h10;
  // own channel bits in a tdm frame (two 32-bit slots)
  localparam logic [7:0] OWN_BITS = 8'h40;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  // synchroniser bank bit positions
  localparam int SY_PWRDN = 0;
  localparam int SY_MODE = 1;
  localparam int SY_MUTE = 2;
  localparam int SY_SHORT = 3;
  localparam int SY_SLOW = 4;
  localparam int SY_DEEMPH_LO = 5;
  localparam int SY_WL_LO = 7;
  localparam int SY_BYPASS = 9;
  localparam int SY_TDM = 10;
  localparam int SY_OVC = 11;
  localparam int SY_OVV = 12;
  localparam int SY_LRCK = 13;
  localparam int SY_BCLK = 14;
  localparam int SY_CASC = 15;
  localparam int SYNC_W = 16;
endpackage : omf_pkg

// File: verilog/omf_ramp_if.sv
// carrier between the control logic and the attenuation ramp
`timescale 1ns/100ps
interface omf_ramp_if;
  import omf_pkg::*;
  logic frameTick;
  logic request;
  logic [2:0] periodSel;
  logic clear;
  logic [LEVEL_W-1:0] clearLevel;
  logic [LEVEL_W-1:0] level;
  logic busy;
  modport ctrl (output frameTick, request, periodSel, clear, clearLevel, input level, busy);
  modport ramp (input frameTick, request, periodSel, clear, clearLevel, output level, busy);
endinterface : omf_ramp_if

// File: verilog/omf_sync.sv
// two flip-flop synchroniser bank for the pin inputs
`timescale 1ns/100ps
module omf_sync import omf_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [SYNC_W-1:0] din, // raw pin levels
  output logic [SYNC_W-1:0] dout // synchronised levels
);
  logic [SYNC_W-1:0] stage1;

  // one pair of flops per pin, first stage read only by the second
  genvar i;
  for (i = 0; i < SYNC_W; i++) begin : g_bit
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        stage1[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        stage1[i] <= din[i];
        dout[i] <= stage1[i];
      end
    end
  end
endmodule : omf_sync

// File: verilog/omf_ramp.sv
// soft mute attenuation ramp, one step per frame or per prescaled frame
`timescale 1ns/100ps
module omf_ramp import omf_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic rst, // asynchronous reset, active high
  omf_ramp_if.ramp rp // ramp control and level
);
  logic [PRESCALE_W-1:0] prescale;
  logic [PRESCALE_W-1:0] limit;
  logic [2:0] code;

  // reserved period codes fall back to the default period
  always_comb begin
    code = (rp.periodSel > PERIOD_LAST) ? PERIOD_DEFAULT : rp.periodSel;
    limit = PRESCALE_W'((32'h1 << code) - 32'h1);
  end

  // ramp is busy until the level sits at the requested end
  assign rp.busy = rp.request ? (rp.level != LEVEL_MUTE) : (rp.level != LEVEL_FULL);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rp.level <= LEVEL_FULL;
      prescale <= '0;
    end else if (rp.clear) begin
      rp.level <= rp.clearLevel;
      prescale <= '0;
    end else if (rp.frameTick) begin
      if (prescale >= limit) begin
        prescale <= '0;
        if (rp.request && rp.level != LEVEL_MUTE) begin
          rp.level <= rp.level - 11'h001;
        end else if (!rp.request && rp.level != LEVEL_FULL) begin
          rp.level <= rp.level + 11'h001;
        end
      end else begin
        prescale <= prescale + 5'h01;
      end
    end
  end
endmodule : omf_ramp

// File: bench/omf_top_props.sv
// concurrent checks on the ports of the output mute and filter control block
`timescale 1ns/100ps
module omf_top_props import omf_pkg::*; (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic power_down_n, // power-down pin
  input wire logic control_mode_select, // parallel when high
  input wire logic short_delay_select, // filter pin
  input wire logic slow_rolloff_select, // filter pin
  input wire logic [1:0] deemphasis_select, // de-emphasis pins
  input wire logic over_current, // regulator detect
  input wire logic over_voltage, // regulator detect
  input wire logic serial_data_out, // serial data
  input wire logic fault_status_out, // fault flag
  input wire logic regulator_enable, // regulator on
  input wire logic [1:0] filter_mode, // chosen filter
  input wire logic [1:0] deemph_mode // chosen de-emphasis
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // power-down holds the flag high and the line low
  property p_off_flag;
    !power_down_n[*4] |-> fault_status_out;
  endproperty
  a_off_flag: assert property (p_off_flag) else $error("flag low in power-down");
  property p_off_data;
    !power_down_n[*4] |-> !serial_data_out;
  endproperty
  a_off_data: assert property (p_off_data) else $error("data high in power-down");
  // a regulator fault trips the flag and stays until power-down
  property p_trip;
    (over_current || over_voltage)[*4] |-> fault_status_out && !regulator_enable;
  endproperty
  a_trip: assert property (p_trip) else $error("fault did not trip");
  property p_hold;
    power_down_n[*6] ##0 fault_status_out |=> fault_status_out;
  endproperty
  a_hold: assert property (p_hold) else $error("fault flag lost");
  property p_clear;
    (!power_down_n && !over_current && !over_voltage) ##1
      (power_down_n && !over_current && !over_voltage)[*6] |-> !fault_status_out;
  endproperty
  a_clear: assert property (p_clear) else $error("flag high in normal run");
  // parallel control follows the pins
  property p_par_filt;
    (control_mode_select && $stable({short_delay_select, slow_rolloff_select}))[*5]
      |-> filter_mode == {short_delay_select, slow_rolloff_select};
  endproperty
  a_par_filt: assert property (p_par_filt) else $error("filter not from pins");
  property p_par_deem;
    (control_mode_select && $stable(deemphasis_select))[*5] |-> deemph_mode == deemphasis_select;
  endproperty
  a_par_deem: assert property (p_par_deem) else $error("de-emphasis not from pins");
  // apb answers after one wait state with a one-cycle ready
  property p_rdy;
    psel && $rose(penable) |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing wrong");
  property p_err;
    pready |-> pslverr == !(paddr == ADDR_CONTROL || paddr == ADDR_STATUS);
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
endmodule : omf_top_props

// File: bench/omf_rx_model.sv
// downstream serial receiver: makes the output clocks and captures left words
`timescale 1ns/100ps
module omf_rx_model (
  input wire logic fast, // one frame per bit clock when high
  input wire logic tdm, // 128-bit tdm frames when high
  input wire logic sdata, // serial data from the block
  output logic bitClk, // bit clock, 320 ns
  output logic frameClk, // frame clock
  output logic [31:0] rxLeft // last word ending at bit 31 of a 64-bit half
);
  logic [6:0] bitPos;
  logic [31:0] shiftIn;
  ////////////////////////////////////////////////////////////
  // free-running bit clock, phase unrelated to the system clock
  initial begin
    bitClk = 1'b0;
    bitPos = 7'h7f;
    shiftIn = 32'h0;
    rxLeft = 32'h0;
    #37;
    forever #160 bitClk = ~bitClk;
  end
  // frame high for the left half of 64 bits, the first 64 of 128 in tdm, or one per bit
  always @(negedge bitClk) bitPos <= bitPos + 7'h01;
  assign frameClk = fast ? bitClk : tdm ? !bitPos[6] : (bitPos[5:0] < 6'h20);
  // data moves after falling edges, so take it msb first on rising edges
  // in tdm the word held at a frame start is the first cascade slot
  always @(posedge bitClk) begin
    shiftIn <= {shiftIn[30:0], sdata};
    if (bitPos[5:0] == 6'h1f) rxLeft <= {shiftIn[30:0], sdata};
  end
endmodule : omf_rx_model

// File: bench/omf_top_test.sv
// self-checking bench for the output mute and filter control block
`timescale 1ns/100ps
module omf_top_test import omf_pkg::*; ;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fast = 1'b1;
  logic power_down_n = 1'b1, control_mode_select = 1'b0, soft_mute_request = 1'b0;
  logic short_delay_select = 1'b0, slow_rolloff_select = 1'b0, bypass_mode = 1'b0;
  logic tdm_mode = 1'b0, over_current = 1'b0, over_voltage = 1'b0, cascade_tdm_in = 1'b0;
  logic [1:0] deemphasis_select = 2'b11, output_word_length = 2'b00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, sample_left = 32'h0, sample_right = 32'h0;
  logic pready, pslverr, serial_data_out, fault_status_out, regulator_enable, lastErr;
  logic output_frame_clock, output_bit_clock;
  logic [1:0] filter_mode, deemph_mode;
  logic [31:0] prdata, rxLeft, rdData;
  logic [10:0] level;
  int checks = 0, miscompares = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  omf_top DUT (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .power_down_n, .control_mode_select, .soft_mute_request, .short_delay_select,
    .slow_rolloff_select, .deemphasis_select, .output_word_length, .bypass_mode, .tdm_mode,
    .over_current, .over_voltage, .output_frame_clock, .output_bit_clock, .cascade_tdm_in,
    .sample_left, .sample_right, .serial_data_out, .fault_status_out, .regulator_enable,
    .filter_mode, .deemph_mode);
  omf_rx_model u_rx (.fast, .tdm(tdm_mode), .sdata(serial_data_out), .bitClk(output_bit_clock),
    .frameClk(output_frame_clock), .rxLeft);
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // one apb transfer held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdData = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // wait some frame rises, then read the attenuation level
  task automatic lvl(input int n);
    repeat (n) @(posedge output_frame_clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    level = rdData[STS_LEVEL_LO +: LEVEL_W];
  endtask : lvl
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    wt(8);
    rst <= 1'b0;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    check("control reset", rdData, 32'h201);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped", {rdData[30:0], lastErr}, 32'h1);
    $display("test registers done");
    apb(1'b1, ADDR_CONTROL, 32'h203);
    lvl(100);
    apb(1'b1, ADDR_CONTROL, 32'h201);
    lvl(60);
    check("turned up", 32'(level < LEVEL_FULL), 32'h1);
    lvl(50);
    check("back to full", 32'(level), 32'h400);
    apb(1'b1, ADDR_CONTROL, 32'h203);
    lvl(1020);
    check("still falling", 32'(level != LEVEL_MUTE), 32'h1);
    lvl(10);
    check("muted", 32'(level), 32'h0);
    // period code only changed while no ramp runs
    apb(1'b1, ADDR_CONTROL, 32'h210);
    apb(1'b1, ADDR_CONTROL, 32'h213);
    lvl(1030);
    check("half period", 32'(level != LEVEL_MUTE), 32'h1);
    lvl(1030);
    check("long muted", 32'(level), 32'h0);
    $display("test ramps done");
    control_mode_select <= 1'b1;
    soft_mute_request <= 1'b1;
    deemphasis_select <= 2'b10;
    short_delay_select <= 1'b1;
    slow_rolloff_select <= 1'b1;
    power_down_n <= 1'b0;
    wt(8);
    power_down_n <= 1'b1;
    lvl(1030);
    check("pin mute default", 32'(level), 32'h0);
    control_mode_select <= 1'b0;
    soft_mute_request <= 1'b0;
    // semi-auto enable changed only while soft reset is low
    apb(1'b1, ADDR_CONTROL, 32'h006);
    apb(1'b1, ADDR_CONTROL, 32'h007);
    apb(1'b1, ADDR_CONTROL, 32'h005);
    lvl(4390);
    check("semi held", 32'(level), 32'h0);
    lvl(1000);
    check("semi rising", 32'(level < LEVEL_FULL), 32'h1);
    lvl(60);
    check("semi released", 32'(level), 32'h400);
    $display("test mute modes done");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_CONTROL, 32'h001 | (c << 9) | (c << 7));
      wt(2);
      check("filter", 32'(filter_mode), {30'h0, c[0], c[1]});
      check("deemph", 32'(deemph_mode), {30'h0, c[1:0]});
    end
    fast <= 1'b0;
    bypass_mode <= 1'b1;
    sample_left <= 32'hc3a51e87;
    apb(1'b1, ADDR_CONTROL, 32'h009);
    repeat (3) @(posedge output_frame_clock);
    check("bypass word", rxLeft, 32'hc3a51e87);
    wt(1);
    output_word_length <= 2'b11;
    apb(1'b1, ADDR_CONTROL, 32'h001);
    repeat (3) @(posedge output_frame_clock);
    check("short word", rxLeft, 32'hc3a5_0000);
    // upstream device sends ones into the cascade input
    wt(1);
    tdm_mode <= 1'b1;
    cascade_tdm_in <= 1'b1;
    repeat (4) @(posedge output_frame_clock);
    check("cascade slot", rxLeft, 32'hffff_ffff);
    wt(1);
    $display("test selects done");
    for (int i = 0; i < 2; i++) begin
      over_current <= (i == 0);
      over_voltage <= (i == 1);
      wt(6);
      over_current <= 1'b0;
      over_voltage <= 1'b0;
      wt(8);
      check("tripped", {30'h0, fault_status_out, regulator_enable}, 32'h2);
      // host cycles power-down promptly
      power_down_n <= 1'b0;
      wt(6);
      check("power-down", {30'h0, fault_status_out, serial_data_out}, 32'h2);
      power_down_n <= 1'b1;
      wt(8);
      check("recovered", {30'h0, fault_status_out, regulator_enable}, 32'h1);
    end
    $display("test faults done");
    end_of_test();
  end
endmodule : omf_top_test
bind omf_top omf_top_props u_props (.clk_sys, .rst, .paddr, .psel, .penable, .pready, .pslverr,
  .power_down_n, .control_mode_select, .short_delay_select, .slow_rolloff_select,
  .deemphasis_select, .over_current, .over_voltage, .serial_data_out, .fault_status_out,
  .regulator_enable, .filter_mode, .deemph_mode);
